// file: adcr_top.sv
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
`include "adcr_regs.svh"

module adcr_top #(
  parameter int unsigned FIRST_CYCLES = `ADCR_FIRST_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [`ADCR_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [`ADCR_RES_W-1:0] filter_result_in,
  input wire logic filter_overflow_in,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic ack_ff;
  logic [31:0] readdata_ff;
  wire [`ADCR_IDX_W-1:0] reg_idx = avs_address_in[`ADCR_ADDR_W-1:2];
  wire bus_req = avs_read_in || avs_write_in;
  wire bus_take = bus_req && ack_ff;
  wire rd_capture = avs_read_in && !ack_ff;
  wire wr_take = avs_write_in && ack_ff && avs_byteenable_in[0];
  wire sel_upper = (reg_idx == `ADCR_IDX_UPPER);
  wire sel_lower = (reg_idx == `ADCR_IDX_LOWER);
  wire sel_ctrl = (reg_idx == `ADCR_IDX_CTRL);
  wire sel_stat = (reg_idx == `ADCR_IDX_STAT);
  wire sel_clr = (reg_idx == `ADCR_IDX_CLR);
  wire sel_en = (reg_idx == `ADCR_IDX_EN);
  wire [7:0] wbyte = avs_writedata_in[7:0];

  // one wait state on every access, so the answer timing is fixed
  assign avs_waitrequest_out = bus_req && !ack_ff;
  assign avs_readdata_out = readdata_ff;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req && !ack_ff;
  end

  // ---------------------------------------------------------------
  // control and core wiring
  // ---------------------------------------------------------------
  adcr_core_if core();

  logic continuous_ff;
  logic [`ADCR_EVT_W-1:0] en_ff;
  wire start_pulse = wr_take && sel_ctrl && wbyte[`ADCR_CTRL_BUSY_POS];
  wire [`ADCR_EVT_W-1:0] clr_bits = (wr_take && sel_clr) ?
                                    wbyte[`ADCR_EVT_W-1:0] : '0;

  assign core.start = start_pulse;
  assign core.continuous = continuous_ff;
  assign core.en = en_ff;
  assign core.clr = clr_bits;
  assign core.evt[`ADCR_EVT_DONE] = core.done;
  assign core.evt[`ADCR_EVT_FLAG] = core.done && filter_overflow_in;
  assign irq_out = core.irq;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      continuous_ff <= 1'b0;
      en_ff <= '0;
    end
    else
    begin
      if (wr_take && sel_ctrl)
        continuous_ff <= wbyte[`ADCR_CTRL_REPEAT_POS];
      if (wr_take && sel_en)
        en_ff <= wbyte[`ADCR_EVT_W-1:0];
    end
  end

  adcr_seq #(
    .FIRST_CYCLES(FIRST_CYCLES)
  ) u_seq (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .core(core.seq_mp)
  );

  adcr_irq u_irq (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .core(core.irq_mp)
  );

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  adcr_pkg::adcr_byte_t upper_ff;
  adcr_pkg::adcr_byte_t lower_ff;
  logic [`ADCR_LOW_W-1:0] live_low_ff;
  logic live_flag_ff;
  wire upper_read = rd_capture && sel_upper;
  wire [`ADCR_LOW_W-1:0] res_low = filter_result_in[`ADCR_LOW_W-1:0];
  wire [7:0] res_high = filter_result_in[`ADCR_RES_W-1:`ADCR_LOW_W];
  adcr_pkg::adcr_byte_t lower_image;

  // low bits sit at the top, overflow at bit zero, the rest reads zero
  always_comb
  begin
    lower_image = `ADCR_BYTE_RST;
    lower_image[`ADCR_LOW_POS +: `ADCR_LOW_W] = live_low_ff;
    lower_image[`ADCR_FLAG_POS] = live_flag_ff;
  end

  // the live low bits are a shadow that software never sees directly;
  // only an upper read moves them into view, keeping the pair coherent
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      upper_ff <= `ADCR_BYTE_RST;
      live_low_ff <= '0;
      live_flag_ff <= 1'b0;
    end
    else if (core.done)
    begin
      upper_ff <= res_high;
      live_low_ff <= res_low;
      live_flag_ff <= filter_overflow_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      lower_ff <= `ADCR_BYTE_RST;
    else if (upper_read)
      lower_ff <= lower_image;
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // result registers have no write path at all
  wire [7:0] ctrl_image = {6'h00, core.busy, continuous_ff};
  wire [7:0] stat_image = {6'h00, core.status};
  wire [7:0] en_image = {6'h00, en_ff};
  wire [7:0] rd_byte = sel_upper ? upper_ff :
                       sel_lower ? lower_ff :
                       sel_ctrl ? ctrl_image :
                       sel_stat ? stat_image :
                       sel_en ? en_image : 8'h00;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      readdata_ff <= 32'h00000000;
    else if (rd_capture)
      readdata_ff <= {24'h000000, rd_byte};
  end

  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  logic [`ADCR_CNT_W-1:0] gap_ff;
  logic from_start_ff;
  logic chain_ff;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      gap_ff <= '0;
      from_start_ff <= 1'b0;
      chain_ff <= 1'b0;
    end
    else if (core.start)
    begin
      gap_ff <= '0;
      from_start_ff <= 1'b1;
      chain_ff <= 1'b0;
    end
    else if (core.done)
    begin
      gap_ff <= '0;
      from_start_ff <= 1'b0;
      chain_ff <= continuous_ff;
    end
    else
    begin
      gap_ff <= gap_ff + 1'b1;
      if (!continuous_ff)
        chain_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  first_delay_a: assert property (
    core.done && from_start_ff |-> gap_ff == `ADCR_CNT_W'(FIRST_CYCLES - 1))
    else $error("first result not at the single-shot delay");

  repeat_period_a: assert property (
    core.done && chain_ff |-> gap_ff == `ADCR_CNT_W'(`ADCR_REPEAT_CYCLES - 1))
    else $error("continuous result period wrong");

  single_once_a: assert property (
    core.done && !continuous_ff && !core.start |=> !core.done [*8])
    else $error("single-shot produced a second result");

  busy_flag_a: assert property (
    core.start |=> core.busy && !core.done)
    else $error("conversion start did not raise busy");

  result_load_a: assert property (
    core.done |=> upper_ff == $past(filter_result_in[10:3]) &&
      live_low_ff == $past(filter_result_in[2:0]))
    else $error("completed result not placed in registers");

  low_latch_a: assert property (
    upper_read && !core.done ##1 avs_read_in && !avs_waitrequest_out
    |=> lower_ff[7:5] == $past(live_low_ff, 2) &&
      lower_ff[0] == $past(live_flag_ff, 2))
    else $error("upper read did not latch low bits");

  upper_ro_a: assert property (
    avs_write_in && sel_upper && !core.done |=> $stable(upper_ff))
    else $error("write altered the upper result");

  lower_ro_a: assert property (
    avs_write_in && sel_lower |=> $stable(lower_ff))
    else $error("write altered the lower result");

  overflow_flag_a: assert property (
    core.done && filter_overflow_in |=> live_flag_ff && core.status[1])
    else $error("overflow not flagged for the sample");

  wait_answer_a: assert property (
    bus_req && !ack_ff |=> !avs_waitrequest_out)
    else $error("bus answer later than one wait state");

  // ---------------------------------------------------------------
  // read path, result, busy, interrupt and settings checks
  // ---------------------------------------------------------------
  upper_read_a: assert property (
    rd_capture && sel_upper |=> avs_readdata_out == {24'h000000, $past(upper_ff)})
    else $error("upper read returned the wrong byte");

  lower_read_a: assert property (
    rd_capture && sel_lower |=> avs_readdata_out == {24'h000000, $past(lower_ff)})
    else $error("lower read returned the wrong byte");

  lower_pad_a: assert property (
    lower_ff[4:1] == 4'h0)
    else $error("unused lower bits not zero");

  read_pad_a: assert property (
    avs_readdata_out[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  done_status_a: assert property (
    core.done |=> core.status[0])
    else $error("completion did not set status");

  busy_end_a: assert property (
    core.done |=> !core.busy)
    else $error("busy still set after the first result");

  busy_hold_a: assert property (
    core.busy && !core.done && !core.start |=> core.busy)
    else $error("busy dropped before the result");

  chain_busy_a: assert property (
    chain_ff |-> !core.busy)
    else $error("busy set during continuous repeats");

  result_hold_a: assert property (
    !core.done |=> $stable(upper_ff) && $stable(live_low_ff))
    else $error("result changed without a completion");

  lower_hold_a: assert property (
    !upper_read |=> $stable(lower_ff))
    else $error("lower changed without an upper read");

  low_capture_a: assert property (
    upper_read |=> lower_ff[7:5] == $past(live_low_ff))
    else $error("upper read captured wrong low bits");

  flag_capture_a: assert property (
    upper_read |=> lower_ff[0] == $past(live_flag_ff))
    else $error("upper read captured wrong overflow flag");

  no_flag_a: assert property (
    core.done && !filter_overflow_in |=> !live_flag_ff)
    else $error("overflow flag set for a clean sample");

  read_hold_a: assert property (
    !rd_capture |=> $stable(avs_readdata_out))
    else $error("read data changed outside a read");

  stat_read_a: assert property (
    rd_capture && sel_stat |=> avs_readdata_out[1:0] == $past(core.status))
    else $error("status read returned the wrong bits");

  en_read_a: assert property (
    rd_capture && sel_en |=> avs_readdata_out[1:0] == $past(en_ff))
    else $error("enable read returned the wrong bits");

  // an enable written in the same cycle may legally mask the new event
  irq_raise_a: assert property (
    core.done && en_ff[0] && !(wr_take && sel_en) |=> irq_out)
    else $error("enabled completion did not raise the interrupt");

  clear_status_a: assert property (
    wr_take && sel_clr && wbyte[0] && !core.done |=> !core.status[0])
    else $error("clear did not drop the status bit");

  // writes without the low byte lane must leave the settings alone
  lane_ignore_a: assert property (
    avs_write_in && !avs_byteenable_in[0] |=> $stable(en_ff) && $stable(continuous_ff))
    else $error("write without byte lane zero took effect");

endmodule

// file: adcr_regs.svh
`ifndef ADCR_REGS_SVH
`define ADCR_REGS_SVH

// word indices; byte address is four times the index
`define ADCR_ADDR_W 14
`define ADCR_IDX_W 12
`define ADCR_IDX_UPPER 12'hF72
`define ADCR_IDX_LOWER 12'hF73
`define ADCR_IDX_CTRL 12'hF74
`define ADCR_IDX_STAT 12'hF75
`define ADCR_IDX_CLR 12'hF76
`define ADCR_IDX_EN 12'hF77

`define ADCR_RES_W 11
`define ADCR_LOW_W 3
`define ADCR_LOW_POS 5
`define ADCR_FLAG_POS 0
`define ADCR_CTRL_REPEAT_POS 0
`define ADCR_CTRL_BUSY_POS 1
`define ADCR_EVT_W 2
`define ADCR_EVT_DONE 0
`define ADCR_EVT_FLAG 1

`define ADCR_BYTE_RST 8'h00
`define ADCR_FIRST_CYCLES 5129
`define ADCR_REPEAT_CYCLES 256
`define ADCR_CNT_W 13

`endif

// file: adcr_pkg.sv
package adcr_pkg;

  typedef enum logic [2:0]
  {
    st_idle = 3'h1,
    st_first = 3'h2,
    st_run = 3'h4
  } adcr_state_t;

  typedef logic [7:0] adcr_byte_t;

endpackage

// file: adcr_core_if.sv
`timescale 1ns/100ps
`include "adcr_regs.svh"

interface adcr_core_if;
  logic start;
  logic continuous;
  logic done;
  logic busy;
  logic [`ADCR_EVT_W-1:0] evt;
  logic [`ADCR_EVT_W-1:0] clr;
  logic [`ADCR_EVT_W-1:0] en;
  logic [`ADCR_EVT_W-1:0] status;
  logic irq;
  modport seq_mp(input start, input continuous, output done, output busy);
  modport irq_mp(input evt, input clr, input en, output status, output irq);
endinterface

// file: adcr_seq.sv
`timescale 1ns/100ps
`include "adcr_regs.svh"

module adcr_seq #(
  parameter int unsigned FIRST_CYCLES = `ADCR_FIRST_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  adcr_core_if.seq_mp core
);
  adcr_pkg::adcr_state_t state_ff;
  adcr_pkg::adcr_state_t nxt_state;
  logic [`ADCR_CNT_W-1:0] cnt_ff;
  logic [`ADCR_CNT_W-1:0] nxt_cnt;
  wire cnt_zero = (cnt_ff == '0);
  wire in_conv = (state_ff != adcr_pkg::st_idle);
  wire [`ADCR_CNT_W-1:0] first_load = `ADCR_CNT_W'(FIRST_CYCLES - 1);
  wire [`ADCR_CNT_W-1:0] repeat_load = `ADCR_CNT_W'(`ADCR_REPEAT_CYCLES - 1);

  // a restart swallows the completion that would fall in the same cycle
  assign core.done = in_conv && cnt_zero && !core.start;
  assign core.busy = (state_ff == adcr_pkg::st_first);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    if (core.start)
    begin
      nxt_state = adcr_pkg::st_first;
      nxt_cnt = first_load;
    end
    else
    begin
      case (state_ff)
        adcr_pkg::st_idle:
        begin
          nxt_cnt = cnt_ff;
        end
        adcr_pkg::st_first, adcr_pkg::st_run:
        begin
          if (state_ff == adcr_pkg::st_run && !core.continuous)
            nxt_state = adcr_pkg::st_idle;
          else if (cnt_zero && core.continuous)
          begin
            nxt_state = adcr_pkg::st_run;
            nxt_cnt = repeat_load;
          end
          else if (cnt_zero)
            nxt_state = adcr_pkg::st_idle;
          else
            nxt_cnt = cnt_ff - 1'b1;
        end
        default:
        begin
          nxt_state = adcr_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_ff <= adcr_pkg::st_idle;
      cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// file: adcr_irq.sv
`timescale 1ns/100ps
`include "adcr_regs.svh"

module adcr_irq (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  adcr_core_if.irq_mp core
);
  genvar i;
  generate
    for (i = 0; i < `ADCR_EVT_W; i = i + 1)
    begin : g_bit
      logic sticky_ff;
      // a new event outranks a clear arriving in the same cycle
      always_ff @(posedge clk_sys_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
          sticky_ff <= 1'b0;
        else if (core.evt[i])
          sticky_ff <= 1'b1;
        else if (core.clr[i])
          sticky_ff <= 1'b0;
      end
      assign core.status[i] = sticky_ff;
    end
  endgenerate

  assign core.irq = |(core.status & core.en);
endmodule

// file: adcr_top_bench.sv
`timescale 1ns/100ps
`include "adcr_regs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module adcr_top_bench;
  // short first count keeps the run small; only the first-result check and the masked wait below derive from it
  localparam int unsigned FC = 20;
  localparam int LIMIT = 10000;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [`ADCR_ADDR_W-1:0] addr = 14'h0000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] be = 4'h0;
  logic [`ADCR_RES_W-1:0] fres = 11'h000;
  logic fovf = 1'b0;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  logic irq_d = 1'b0;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int rise_prev = 0;
  int rise_last = 0;
  int n;
  logic [31:0] exp_q[$];
  string nm_q[$];
  logic [31:0] exp_v;
  string nm_v;
  logic [`ADCR_RES_W-1:0] snap;
  logic snap_flag;

  adcr_top #(.FIRST_CYCLES(FC)) i_dut (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .avs_address_in(addr),
    .avs_read_in(rd),
    .avs_write_in(wr),
    .avs_writedata_in(wdata),
    .avs_byteenable_in(be),
    .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req),
    .filter_result_in(fres),
    .filter_overflow_in(fovf),
    .irq_out(irq)
  );

  initial
  begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] hi(input logic [10:0] r);
    return {24'h000000, r[10:3]};
  endfunction

  function automatic logic [31:0] lo(input logic [10:0] r, input logic o);
    return {24'h000000, r[2:0], 4'h0, o};
  endfunction

  task automatic tally_and_finish;
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // request held until waitrequest is sampled low, released only after that edge
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk_sys_in);
    addr <= {idx, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= d;
    be <= b;
    do @(posedge clk_sys_in); while (wait_req !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    bus(1'b0, idx, $urandom, 4'hF);
  endtask

  task automatic wreg(input logic [11:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask

  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 4000)
    begin
      @(posedge clk_sys_in);
      n++;
    end
  endtask

  // read results are compared where they are taken; also edge log and timeout
  always @(posedge clk_sys_in)
  begin
    cyc++;
    irq_d <= irq;
    if (irq === 1'b1 && irq_d !== 1'b1)
    begin
      rise_prev = rise_last;
      rise_last = cyc;
    end
    if (rd && wait_req === 1'b0 && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      nm_v = nm_q.pop_front();
      `CHK(nm_v, exp_v, rdata)
    end
    if (cyc > LIMIT)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(54));
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    wreg(12'h123, $urandom);
    rchk(12'h123, 32'h0, "unmapped");
    bus(1'b1, `ADCR_IDX_EN, 32'h1, 4'hE);
    rchk(`ADCR_IDX_EN, 32'h0, "enable");
    wreg(`ADCR_IDX_EN, 32'h1);
    fres <= 11'($urandom);
    fovf <= 1'($urandom);
    wreg(`ADCR_IDX_CTRL, 32'h2);
    rchk(`ADCR_IDX_CTRL, 32'h2, "busy");
    wait_irq;
    // three edges go to the busy read before the wait starts counting
    `CHK("first_wait", 1'b1, (n >= FC - 3 && n <= FC - 1))
    rchk(`ADCR_IDX_CTRL, 32'h0, "idle");
    rchk(`ADCR_IDX_STAT, {30'h0, fovf, 1'b1}, "status");
    rchk(`ADCR_IDX_UPPER, hi(fres), "upper");
    wreg(`ADCR_IDX_UPPER, 32'hFF);
    wreg(`ADCR_IDX_LOWER, 32'hFF);
    rchk(`ADCR_IDX_LOWER, lo(fres, fovf), "lower");
    snap = fres;
    snap_flag = fovf;
    fres <= ~fres;
    fovf <= ~fovf;
    repeat (300) @(posedge clk_sys_in);
    rchk(`ADCR_IDX_UPPER, hi(snap), "upper_hold");
    rchk(`ADCR_IDX_LOWER, lo(snap, snap_flag), "lower_hold");
    wreg(`ADCR_IDX_CLR, 32'h3);
    @(posedge clk_sys_in);
    `CHK("irq_clear", 1'b0, irq)
    fres <= 11'($urandom);
    fovf <= 1'($urandom);
    wreg(`ADCR_IDX_CTRL, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      wait_irq;
      if (i > 0)
        rchk(`ADCR_IDX_LOWER, lo(snap, snap_flag), "stale_lower");
      rchk(`ADCR_IDX_UPPER, hi(fres), "continuous_select_upper");
      rchk(`ADCR_IDX_LOWER, lo(fres, fovf), "continuous_select_lower");
      if (i > 0)
        `CHK("period", 256, rise_last - rise_prev)
      snap = fres;
      snap_flag = fovf;
      wreg(`ADCR_IDX_CLR, 32'h3);
      // let the clear reach the interrupt before the next wait looks at it
      @(posedge clk_sys_in);
      fres <= 11'($urandom);
      fovf <= 1'($urandom);
    end
    wreg(`ADCR_IDX_CTRL, 32'h0);
    wreg(`ADCR_IDX_CLR, 32'h3);
    repeat (600) @(posedge clk_sys_in);
    rchk(`ADCR_IDX_STAT, 32'h0, "stopped");
    wreg(`ADCR_IDX_EN, 32'h2);
    fovf <= 1'b0;
    wreg(`ADCR_IDX_CTRL, 32'h2);
    repeat (FC + 10) @(posedge clk_sys_in);
    `CHK("irq_masked", 1'b0, irq)
    rchk(`ADCR_IDX_STAT, 32'h1, "masked_status");
    wreg(`ADCR_IDX_EN, 32'h1);
    @(posedge clk_sys_in);
    `CHK("irq_unmasked", 1'b1, irq)
    wreg(`ADCR_IDX_CLR, 32'h1);
    @(posedge clk_sys_in);
    `CHK("irq_cleared", 1'b0, irq)
    tally_and_finish();
  end
endmodule
